// [tmc_channel.sv]
// What this block does
// - accept a 14-bit diode factor code, nominally round(4572 / emission coefficient)
// - two-bit transducer field: off, beta PNP, differential, single-ended
// - signed offset added to every sample for readout and both alarms
// - offset is 9-bit two's complement, quarter-degree steps
// - two alarm comparators, each with 9-bit signed whole-degree limit
// - open and short detection only on remote diode channels
// - fault readings 0x3FF and 0x401, swapped by polarity bit
// - exponential averaging before readout, coefficient 1, 8 or 16
// - filtered measurement is readable by the host
// - each alarm has depth field, effective depth is field plus one
// - each alarm has 7-bit signed whole-degree hysteresis
// - any configuration rewrite restarts measurement and alarm logic
// - each of three channels has its own configuration set
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_channel
  import tmc_pkg::*;
#(
  parameter bit IS_REMOTE = 1'b1
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_cfg_write,
  input  wire logic [`TMC_FACTOR_W-1:0]   i_diode_factor,
  input  wire logic [1:0]                 i_transducer_sel,
  input  wire logic [`TMC_OFFSET_W-1:0]   i_offset,
  input  wire logic [`TMC_LIMIT_W-1:0]    i_first_alarm_limit,
  input  wire logic [`TMC_LIMIT_W-1:0]    i_second_alarm_limit,
  input  wire logic                       i_fault_read_polarity,
  input  wire logic [1:0]                 i_averaging_coefficient,
  input  wire logic [`TMC_DEPTH_W-1:0]    i_first_alarm_depth,
  input  wire logic [`TMC_DEPTH_W-1:0]    i_second_alarm_depth,
  input  wire logic [`TMC_HYST_W-1:0]     i_first_alarm_hysteresis,
  input  wire logic [`TMC_HYST_W-1:0]     i_second_alarm_hysteresis,
  input  wire logic                       i_sample_valid,
  input  wire logic [`TMC_TEMP_W-1:0]     i_raw_temp,
  input  wire logic                       i_diode_open,
  input  wire logic                       i_diode_short,
  output logic [`TMC_FACTOR_W-1:0]        o_diode_factor,
  output logic [1:0]                      o_sense_mode,
  output logic                            o_channel_enabled,
  output logic [`TMC_TEMP_W-1:0]          o_temp,
  output logic                            o_temp_valid,
  output logic                            o_fault,
  output logic                            o_first_temp_comparator,
  output logic                            o_second_temp_comparator
);

  localparam int TW = `TMC_TEMP_W + 1;
  localparam int AW = `TMC_TEMP_W + `TMC_FRAC_W;
  localparam int DW = AW + 1;

  // ----------------------------------------------------------------
  // notes for users of this channel
  // ----------------------------------------------------------------
  // one instance per channel: two remote, one on-die with IS_REMOTE at 0
  // diode factor is only echoed, transducer mode is echoed and decoded for off; the analog side uses them
  // under-temperature alarms read a comparator inverted, also with negative hysteresis
  // alarms see unfiltered samples, so averaging never delays a trip
  // readout floors the average: a small bias traded for no rounding adder
  // a fault sample freezes average and alarms instead of polluting them
  // holding the transducer field at off keeps state, average, readout and alarms in restart; the echo registers keep tracking
  // averaging code 11 is undefined and runs as no averaging

  // ----------------------------------------------------------------
  // state and configuration capture
  // ----------------------------------------------------------------
  tmc_state_t      state;
  tmc_state_t      next_state;
  logic [AW-1:0]   acc;
  logic [1:0]      alarm_state;

  wire logic enable  = i_transducer_sel != `TMC_XDCR_OFF;
  wire logic restart = i_cfg_write || !enable;
  // fault flags only count on the remote diode channels
  wire logic fault_now = IS_REMOTE && (i_diode_open || i_diode_short);

  // ----------------------------------------------------------------
  // state sequencing
  // ----------------------------------------------------------------
  // a first good sample must load the average before running it
  always_comb begin
    next_state = state;
    case (state)
      TMC_ST_OFF:   next_state = enable ? TMC_ST_PRIME : TMC_ST_OFF;
      TMC_ST_PRIME: next_state = (i_sample_valid && !fault_now) ? TMC_ST_RUN : TMC_ST_PRIME;
      TMC_ST_RUN:   next_state = TMC_ST_RUN;
      default:      next_state = TMC_ST_OFF;
    endcase
    // restart wins over every transition
    if (restart) begin
      next_state = enable ? TMC_ST_PRIME : TMC_ST_OFF;
    end
  end

  // ----------------------------------------------------------------
  // offset correction
  // ----------------------------------------------------------------
  // clamp keeps ordinary readings clear of the lowest code, so 0x400 never shows
  wire logic signed [TW-1:0] raw_x = {i_raw_temp[`TMC_TEMP_W-1], i_raw_temp};
  wire logic signed [TW-1:0] off_x = {{(TW-`TMC_OFFSET_W){i_offset[8]}}, i_offset};
  wire logic signed [TW-1:0] corr  = raw_x + off_x;
  wire logic signed [TW-1:0] hi_x  = {1'b0, `TMC_READ_MAX};
  wire logic signed [TW-1:0] lo_x  = {1'b1, `TMC_READ_MIN};
  wire logic signed [TW-1:0] corr_c = (corr > hi_x) ? hi_x : ((corr < lo_x) ? lo_x : corr);

  // ----------------------------------------------------------------
  // fault detection and readout codes
  // ----------------------------------------------------------------
  // a short takes precedence when both flags are up
  wire logic read_high = i_diode_short ? !i_fault_read_polarity : i_fault_read_polarity;
  wire logic [`TMC_TEMP_W-1:0] fault_code = read_high ? `TMC_READ_MAX : `TMC_READ_MIN;

  // ----------------------------------------------------------------
  // averaging step decode
  // ----------------------------------------------------------------
  // code 11 has no defined coefficient and behaves as no averaging
  function automatic logic signed [DW-1:0] avg_step(
    input logic [1:0]           code,
    input logic signed [DW-1:0] d
  );
    logic signed [DW-1:0] r;
    case (code)
      `TMC_AVG_EIGHT:   r = d >>> `TMC_SHIFT_EIGHT;
      `TMC_AVG_SIXTEEN: r = d >>> `TMC_SHIFT_SIXTEEN;
      default:          r = d;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // exponential averaging
  // ----------------------------------------------------------------
  wire logic signed [DW-1:0] x_scaled = {corr_c, `TMC_FRAC_W'h0};
  wire logic signed [DW-1:0] acc_x    = {acc[AW-1], acc};
  wire logic signed [DW-1:0] diff     = x_scaled - acc_x;
  wire logic signed [DW-1:0] step     = avg_step(i_averaging_coefficient, diff);
  wire logic signed [DW-1:0] acc_sum  = acc_x + step;
  wire logic [AW-1:0] next_acc = (state == TMC_ST_RUN) ? acc_sum[AW-1:0] : x_scaled[AW-1:0];
  wire logic take = i_sample_valid && !restart && (state != TMC_ST_OFF);
  wire logic good = take && !fault_now;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= TMC_ST_OFF;
      acc   <= '0;
    end else begin
      state <= next_state;
      if (good) begin
        acc <= next_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // readout registers
  // ----------------------------------------------------------------
  wire logic [`TMC_TEMP_W-1:0] filt = next_acc[AW-1:`TMC_FRAC_W];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_temp       <= `TMC_RESET_TEMP;
      o_temp_valid <= 1'b0;
      o_fault      <= 1'b0;
    end else begin
      o_temp_valid <= take;
      if (restart) begin
        o_temp  <= `TMC_RESET_TEMP;
        o_fault <= 1'b0;
      end else if (take) begin
        o_temp  <= fault_now ? fault_code : filt;
        o_fault <= fault_now;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_diode_factor    <= '0;
      o_sense_mode      <= TMC_SENSE_OFF;
      o_channel_enabled <= 1'b0;
    end else begin
      o_diode_factor    <= i_diode_factor;
      o_sense_mode      <= i_transducer_sel;
      o_channel_enabled <= enable;
    end
  end

  // ----------------------------------------------------------------
  // alarm comparators
  // ----------------------------------------------------------------
  wire logic [2*`TMC_LIMIT_W-1:0] limits = {i_second_alarm_limit, i_first_alarm_limit};
  wire logic [2*`TMC_HYST_W-1:0]  hysts  = {i_second_alarm_hysteresis, i_first_alarm_hysteresis};
  wire logic [2*`TMC_DEPTH_W-1:0] depths = {i_second_alarm_depth, i_first_alarm_depth};

  for (genvar g = 0; g < 2; g++) begin : g_alarm
    tmc_alarm #(
      .TW (TW)
    ) u_alarm (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_restart  (restart),
      .i_sample   (good),
      .i_temp     (corr_c),
      .i_limit    (limits[g*`TMC_LIMIT_W +: `TMC_LIMIT_W]),
      .i_hyst     (hysts[g*`TMC_HYST_W +: `TMC_HYST_W]),
      .i_depth    (depths[g*`TMC_DEPTH_W +: `TMC_DEPTH_W]),
      .o_state    (alarm_state[g])
    );
  end

  assign o_first_temp_comparator  = alarm_state[0];
  assign o_second_temp_comparator = alarm_state[1];

endmodule
`default_nettype wire

// [tmc_cfg.svh]
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// ----------------------------------------------------------------
// field widths
// ----------------------------------------------------------------
`define TMC_FACTOR_W     14
`define TMC_OFFSET_W     9
`define TMC_LIMIT_W      9
`define TMC_HYST_W       7
`define TMC_DEPTH_W      4
`define TMC_TEMP_W       11
`define TMC_FRAC_W       4

// ----------------------------------------------------------------
// transducer selection codes
// ----------------------------------------------------------------
`define TMC_XDCR_OFF     2'h0
`define TMC_XDCR_BETA    2'h1
`define TMC_XDCR_DIFF    2'h2
`define TMC_XDCR_SINGLE  2'h3

// ----------------------------------------------------------------
// averaging field codes and shifts
// ----------------------------------------------------------------
`define TMC_AVG_ONE      2'h0
`define TMC_AVG_EIGHT    2'h1
`define TMC_AVG_SIXTEEN  2'h2
`define TMC_SHIFT_EIGHT  3
`define TMC_SHIFT_SIXTEEN 4

// ----------------------------------------------------------------
// readout codes, quarter degrees
// ----------------------------------------------------------------
`define TMC_READ_MAX     11'h3FF
`define TMC_READ_MIN     11'h401
`define TMC_RESET_TEMP   11'h000

`endif

// [tmc_pkg.sv]
package tmc_pkg;

  typedef enum logic [2:0] {
    TMC_ST_OFF   = 3'b001,
    TMC_ST_PRIME = 3'b010,
    TMC_ST_RUN   = 3'b100
  } tmc_state_t;

  typedef enum logic [1:0] {
    TMC_SENSE_OFF    = 2'h0,
    TMC_SENSE_BETA   = 2'h1,
    TMC_SENSE_DIFF   = 2'h2,
    TMC_SENSE_SINGLE = 2'h3
  } tmc_sense_t;

endpackage

// [tmc_alarm.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_alarm
  import tmc_pkg::*;
#(
  parameter int TW = 12
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_restart,
  input  wire logic                      i_sample,
  input  wire logic [TW-1:0]             i_temp,
  input  wire logic [`TMC_LIMIT_W-1:0]   i_limit,
  input  wire logic [`TMC_HYST_W-1:0]    i_hyst,
  input  wire logic [`TMC_DEPTH_W-1:0]   i_depth,
  output logic                           o_state
);

  logic [`TMC_DEPTH_W-1:0] run_count;

  // limit and hysteresis in whole degrees, scaled to quarter degrees
  wire logic signed [TW-1:0] limit_q = {{(TW-11){i_limit[8]}}, i_limit, 2'b00};
  wire logic signed [TW-1:0] hyst_q  = {{(TW-9){i_hyst[6]}}, i_hyst, 2'b00};
  // hysteresis only moves the point of return, not the trip point
  wire logic signed [TW-1:0] eff_q   = o_state ? limit_q + hyst_q : limit_q;
  wire logic                 above   = $signed(i_temp) >= eff_q;
  wire logic                 differs = above != o_state;
  wire logic                 settled = run_count == i_depth;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_state   <= 1'b0;
      run_count <= '0;
    end else if (i_restart) begin
      o_state   <= 1'b0;
      run_count <= '0;
    end else if (i_sample) begin
      if (differs && settled) begin
        o_state   <= above;
        run_count <= '0;
      end else if (differs) begin
        run_count <= run_count + 1'b1;
      end else begin
        run_count <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// [tmc_channel_properties.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_channel_properties (
  input wire logic                   i_core_clk,
  input wire logic                   i_nrst,
  input wire logic                   i_cfg_write,
  input wire logic [1:0]             i_transducer_sel,
  input wire logic                   i_fault_read_polarity,
  input wire logic                   i_sample_valid,
  input wire logic                   i_diode_open,
  input wire logic                   i_diode_short,
  input wire logic [1:0]             o_sense_mode,
  input wire logic                   o_channel_enabled,
  input wire logic [`TMC_TEMP_W-1:0] o_temp,
  input wire logic                   o_temp_valid,
  input wire logic                   o_fault,
  input wire logic                   o_first_temp_comparator,
  input wire logic                   o_second_temp_comparator
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  property p_mode; $past(i_nrst) |-> o_sense_mode == $past(i_transducer_sel)
    && o_channel_enabled == ($past(i_transducer_sel) != 2'h0); endproperty
  a_mode: assert property (p_mode) else $error("sense mode echo wrong");
  property p_taken; o_temp_valid |-> $past(i_sample_valid && !i_cfg_write && i_transducer_sel != 2'h0); endproperty
  a_taken: assert property (p_taken) else $error("readout without a taken sample");
  property p_restart; i_cfg_write |=> o_temp == 11'h000 && !o_fault && !o_temp_valid
    && !o_first_temp_comparator && !o_second_temp_comparator; endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear channel");
  property p_short; o_temp_valid && $past(i_diode_short)
    |-> o_fault && o_temp == ($past(i_fault_read_polarity) ? 11'h401 : 11'h3FF); endproperty
  a_short: assert property (p_short) else $error("short reading wrong");
  property p_open; o_temp_valid && $past(i_diode_open && !i_diode_short)
    |-> o_fault && o_temp == ($past(i_fault_read_polarity) ? 11'h3FF : 11'h401); endproperty
  a_open: assert property (p_open) else $error("open reading wrong");
  property p_first; $changed(o_first_temp_comparator) && !$past(i_cfg_write) && $past(i_transducer_sel) != 2'h0
    |-> o_temp_valid && !o_fault; endproperty
  a_first: assert property (p_first) else $error("first alarm moved without a good sample");
  property p_second; $changed(o_second_temp_comparator) && !$past(i_cfg_write) && $past(i_transducer_sel) != 2'h0
    |-> o_temp_valid && !o_fault; endproperty
  a_second: assert property (p_second) else $error("second alarm moved without a good sample");
  property p_hold; o_temp_valid && o_fault
    |-> $stable(o_first_temp_comparator) && $stable(o_second_temp_comparator); endproperty
  a_hold: assert property (p_hold) else $error("fault sample moved an alarm");
endmodule

`default_nettype wire

// [tmc_host.sv]
`timescale 1ns/100ps
`default_nettype none

module tmc_host (
  input  wire logic        i_core_clk,
  output var logic         o_wr,
  output var logic [13:0]  o_fac,
  output var logic [1:0]   o_sel,
  output var logic [8:0]   o_off,
  output var logic [8:0]   o_lim1,
  output var logic [8:0]   o_lim2,
  output var logic         o_pol,
  output var logic [1:0]   o_avg,
  output var logic [3:0]   o_dep1,
  output var logic [3:0]   o_dep2,
  output var logic [6:0]   o_hys1,
  output var logic [6:0]   o_hys2
);
  initial {o_wr, o_fac, o_sel, o_off, o_lim1, o_lim2, o_pol, o_avg, o_dep1, o_dep2, o_hys1, o_hys2} = '0;

  // host software never writes out-of-range codes, so this model does not
  function automatic logic [8:0] lim_ok(input logic [8:0] v);
    return ($signed(v) < -64) ? 9'h1C0 : (($signed(v) > 155) ? 9'h09B : v);
  endfunction

  task automatic commit();
    if (o_fac < 14'h08EE) o_fac = 14'h08EE;
    if (o_fac > 14'h13D8) o_fac = 14'h13D8;
    o_lim1 = lim_ok(o_lim1);
    o_lim2 = lim_ok(o_lim2);
    // both comparators serve as over-temperature alarms here
    if (!o_hys1[6]) o_hys1 = -o_hys1;
    if (!o_hys2[6]) o_hys2 = -o_hys2;
    @(posedge i_core_clk);
    #1 o_wr = 1'b1;
    @(posedge i_core_clk);
    #1 o_wr = 1'b0;
    @(posedge i_core_clk);
    #1;
  endtask
endmodule

`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic              clk  = 1'b0;
  logic              nrst = 1'b0;
  logic              vld  = 1'b0;
  logic              op   = 1'b0;
  logic              sh   = 1'b0;
  logic [10:0]       raw  = 11'h000;
  logic [31:0]       seed = 32'h0000005D;
  int                n_mismatch = 0;
  int                compares   = 0;
  wire logic         wr, pol, en, tv, fault_read_polarity, al1, al2;
  wire logic [1:0]   sel, avg, mode;
  wire logic [13:0]  fac, fac_q;
  wire logic [8:0]   off, l1, l2;
  wire logic [3:0]   d1, d2;
  wire logic [6:0]   h1, h2;
  wire logic [10:0]  tmp;

  always #10 clk = ~clk;

  tmc_host i_tmc_host (.i_core_clk(clk), .o_wr(wr), .o_fac(fac), .o_sel(sel), .o_off(off), .o_lim1(l1),
    .o_lim2(l2), .o_pol(pol), .o_avg(avg), .o_dep1(d1), .o_dep2(d2), .o_hys1(h1), .o_hys2(h2));

  tmc_channel i_tmc_channel (.i_core_clk(clk), .i_nrst(nrst), .i_cfg_write(wr), .i_diode_factor(fac),
    .i_transducer_sel(sel), .i_offset(off), .i_first_alarm_limit(l1), .i_second_alarm_limit(l2),
    .i_fault_read_polarity(pol), .i_averaging_coefficient(avg), .i_first_alarm_depth(d1),
    .i_second_alarm_depth(d2), .i_first_alarm_hysteresis(h1), .i_second_alarm_hysteresis(h2),
    .i_sample_valid(vld), .i_raw_temp(raw), .i_diode_open(op), .i_diode_short(sh), .o_diode_factor(fac_q),
    .o_sense_mode(mode), .o_channel_enabled(en), .o_temp(tmp), .o_temp_valid(tv), .o_fault(fault_read_polarity),
    .o_first_temp_comparator(al1), .o_second_temp_comparator(al2));

  function automatic void next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction

  function automatic logic [10:0] corr(input logic [10:0] r, input logic [8:0] o);
    int s;
    s = $signed(r) + $signed(o);
    if (s > 1023) s = 1023;
    if (s < -1023) s = -1023;
    return s[10:0];
  endfunction

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic smp(input logic [10:0] r, input logic o, input logic s);
    @(posedge clk);
    #1 vld = 1'b1;
    raw = r;
    op = o;
    sh = s;
    @(posedge clk);
    #1 vld = 1'b0;
    chk(tv, 1'b1);
  endtask

  task automatic cfg(input logic [1:0] s, input logic [1:0] a, input logic p, input logic [8:0] o);
    i_tmc_host.o_sel = s;
    i_tmc_host.o_avg = a;
    i_tmc_host.o_pol = p;
    i_tmc_host.o_off = o;
    i_tmc_host.commit();
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    i_tmc_host.o_fac = 14'h0100;
    i_tmc_host.o_lim1 = 9'h014;
    i_tmc_host.o_lim2 = 9'h1B0;
    i_tmc_host.o_dep1 = 4'h2;
    i_tmc_host.o_hys1 = 7'h02;
    for (int k = 0; k < 4; k++) begin
      cfg(k[1:0], 2'h0, 1'b0, 9'h000);
      chk(mode, k[1:0]);
      chk(en, k != 0);
    end
    chk(fac_q, 14'h08EE);
    cfg(2'h1, 2'h0, 1'b0, 9'h000);
    smp(11'h050, 1'b0, 1'b0);
    chk(al2, 1'b1);
    smp(11'h050, 1'b0, 1'b0);
    chk(al1, 1'b0);
    smp(11'h050, 1'b1, 1'b0);
    smp(11'h050, 1'b0, 1'b0);
    chk(al1, 1'b1);
    repeat (3) smp(11'h048, 1'b0, 1'b0);
    repeat (2) smp(11'h047, 1'b0, 1'b0);
    chk(al1, 1'b1);
    smp(11'h047, 1'b0, 1'b0);
    chk(al1, 1'b0);
    i_tmc_host.commit();
    chk({al1, al2, tmp}, 13'h0000);
    for (int k = 0; k < 6; k++) begin
      logic [1:0] c;
      c = 2'(k / 2 + 1);
      cfg(2'h1, 2'h0, k[0], 9'h000);
      smp(11'h123, c[0], c[1]);
      chk(tmp, (c[1] ^ k[0]) ? 11'h3FF : 11'h401);
      chk(fault_read_polarity, 1'b1);
    end
    for (int k = 0; k < 48; k++) begin
      next_rand();
      if (k % 8 == 0) cfg(2'h1, 2'h0, 1'b0, (k == 0) ? 9'h0FF : ((k == 8) ? 9'h100 : seed[8:0]));
      next_rand();
      smp((k == 0) ? 11'h3FF : ((k == 8) ? 11'h400 : seed[10:0]), 1'b0, 1'b0);
      chk(tmp, corr(raw, off));
    end
    for (int k = 1; k < 4; k++) begin
      cfg(2'h1, k[1:0], 1'b0, 9'h000);
      smp(11'h040, 1'b0, 1'b0);
      chk(tmp, 11'h040);
      smp(11'h0C0, 1'b0, 1'b0);
      chk(tmp, (k == 1) ? 11'h050 : ((k == 2) ? 11'h048 : 11'h0C0));
    end
    wrap_up();
  end
endmodule

bind tmc_channel tmc_channel_properties i_tmc_channel_properties (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_cfg_write(i_cfg_write), .i_transducer_sel(i_transducer_sel), .i_fault_read_polarity(i_fault_read_polarity),
  .i_sample_valid(i_sample_valid), .i_diode_open(i_diode_open), .i_diode_short(i_diode_short),
  .o_sense_mode(o_sense_mode), .o_channel_enabled(o_channel_enabled), .o_temp(o_temp), .o_temp_valid(o_temp_valid),
  .o_fault(o_fault), .o_first_temp_comparator(o_first_temp_comparator),
  .o_second_temp_comparator(o_second_temp_comparator));

`default_nettype wire
